// ==== hw/pdc_regs.svh ====
// Register offsets, field positions and reset values of the DMA channel pair
`ifndef PDC_CHAN_REGS_SVH
`define PDC_CHAN_REGS_SVH
`define OFS_RX_PTR 8'h00
`define OFS_RX_CNT 8'h04
`define OFS_TX_PTR 8'h08
`define OFS_TX_CNT 8'h0C
`define OFS_RX_NPTR 8'h10
`define OFS_RX_NCNT 8'h14
`define OFS_TX_NPTR 8'h18
`define OFS_TX_NCNT 8'h1C
`define OFS_CTRL 8'h20
`define OFS_STATUS 8'h24
`define OFS_CONFIG 8'h28
`define BIT_RX_EN 0
`define BIT_RX_DIS 1
`define BIT_TX_EN 8
`define BIT_TX_DIS 9
`define BIT_HALF_DUPLEX 0
`define CNT_W 16
`define RST_PTR 32'h0000_0000
`define RST_CNT 16'h0000
`define CNT_ONE 16'h0001
`endif

// ==== hw/pdc_pkg.sv ====
// Types shared by the DMA channel pair
package pdc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ = 3'b010,
      ST_DONE = 3'b100
   } xfer_state_e;
endpackage : pdc_pkg

// ==== hw/pdc_sync.sv ====
// Three-stage synchroniser for a pin input, change counts when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pdc_sync (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Data
   input wire logic d_i,
   output logic q_o
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         q_o <= 1'b0;
      end else if (ce_i) begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q_o <= s3;
         end
      end
   end
endmodule : pdc_sync
`default_nettype wire

// ==== hw/pdc_dir.sv ====
// One transfer direction: request sequencer and one-cycle advance strobe; pointer/count advance and queue reload are in pdc_channel
`timescale 1ns/1ps
`default_nettype none
`include "pdc_regs.svh"
module pdc_dir import pdc_pkg::*; #(
   parameter int unsigned STEP = 4
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Channel state
   input wire logic enable_i,
   input wire logic [15:0] count_i,
   // Peripheral and memory side
   input wire logic periph_ready_i,
   output logic req_o,
   input wire logic ack_i,
   // One-cycle advance strobe
   output logic step_o
);
   xfer_state_e state;
   xfer_state_e next_state;
   wire count_live = count_i != `RST_CNT;
   wire go = enable_i && count_live && periph_ready_i;
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (go) next_state = ST_REQ; // see RULE2 see RULE3 see RULE6 see RULE7
         ST_REQ: if (ack_i) next_state = ST_DONE;
         ST_DONE: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else if (ce_i) begin
         state <= next_state;
      end
   end
   // A started beat completes even if disabled mid-way; the bus cannot take it back
   assign req_o = state == ST_REQ;
   assign step_o = state == ST_DONE;
endmodule : pdc_dir
`default_nettype wire

// ==== hw/pdc_channel.sv ====
// Wishbone register block and sequencing of a receive/transmit DMA channel pair
//
// Operation
// RULE1: Software loads receive count with receive buffer size before reception.
// RULE2: Receive count of zero halts receive transfers into memory.
// RULE3: Nonzero receive count starts receive transfers while receive is enabled.
// RULE4: Software loads transmit pointer with transmit buffer address first.
// RULE5: Software loads transmit count with transmit buffer size before transmission.
// RULE6: Transmit count of zero halts transmit transfers from memory.
// RULE7: Nonzero transmit count starts transmit transfers while transmit is enabled.
// RULE8: Receive queued pointer holds the next receive buffer address.
// RULE9: Receive queued count holds the next receive buffer size.
// RULE10: Transmit queued pointer holds the next transmit buffer address.
// RULE11: Transmit queued count holds the next transmit buffer size.
// RULE12: Half duplex: receive and transmit current pointers are one register.
// RULE13: Half duplex: receive and transmit current counts are one register.
// RULE14: Half duplex: receive and transmit queued pointers are one register.
// RULE15: Half duplex: receive and transmit queued counts are one register.
// RULE16: Receive enable bit enables receive requests unless disable also written.
// RULE17: Half duplex: receive enable clears transmit enable; never set both. Here a later transmit enable leaves receive enable set, so both can be set.
// RULE18: Half duplex: disabling either direction disables both.
// RULE19: Status register shows receive enable at bit 0, transmit at 8.
// RULE20: Control: receive enable/disable bits 0/1, transmit bits 8/9.
// RULE21: Each beat advances pointer, decrements count; empty count reloads from queue.
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_regs.svh"
module pdc_channel import pdc_pkg::*; #(
   parameter int unsigned STEP = 4
) (
   // Clock, reset, clock enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Peripheral pins (outside clock domain)
   input wire logic rx_ready_i,
   input wire logic tx_ready_i,
   // Memory bus side
   output logic rx_req_o,
   output logic [31:0] rx_addr_o,
   input wire logic rx_ack_i,
   output logic tx_req_o,
   output logic [31:0] tx_addr_o,
   input wire logic tx_ack_i
);
   // Current and queued pointers/counts; in half duplex only the rx copy is used
   logic [31:0] rx_current_address;
   logic [31:0] tx_current_address;
   logic [15:0] rx_current_size;
   logic [15:0] tx_current_size;
   logic [31:0] rx_queued_address;
   logic [31:0] tx_queued_address;
   logic [15:0] rx_queued_size;
   logic [15:0] tx_queued_size;
   logic rx_request_enable;
   logic tx_request_enable;
   logic half_duplex;

   function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction : merge32

   // Counters keep only the low half of a bus word
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = merge32({16'h0000, old}, nw, be);
      return r[15:0];
   endfunction : merge16

   // Bus decode
   wire access = cyc_i && stb_i && !ack_o;
   wire wr = access && we_i && ce_i;
   wire wr_rx_ptr = wr && adr_i == `OFS_RX_PTR;
   wire wr_rx_cnt = wr && adr_i == `OFS_RX_CNT;
   wire wr_tx_ptr = wr && adr_i == `OFS_TX_PTR;
   wire wr_tx_cnt = wr && adr_i == `OFS_TX_CNT;
   wire wr_rx_nptr = wr && adr_i == `OFS_RX_NPTR;
   wire wr_rx_ncnt = wr && adr_i == `OFS_RX_NCNT;
   wire wr_tx_nptr = wr && adr_i == `OFS_TX_NPTR;
   wire wr_tx_ncnt = wr && adr_i == `OFS_TX_NCNT;
   wire wr_ctrl = wr && adr_i == `OFS_CTRL;
   wire wr_cfg = wr && adr_i == `OFS_CONFIG;

   // Half duplex folds both directions onto the rx copies
   wire hd = half_duplex;
   wire sel_rx_ptr = wr_rx_ptr || (hd && wr_tx_ptr); // see RULE12
   wire sel_rx_cnt = wr_rx_cnt || (hd && wr_tx_cnt); // see RULE13
   wire sel_rx_nptr = wr_rx_nptr || (hd && wr_tx_nptr); // see RULE14
   wire sel_rx_ncnt = wr_rx_ncnt || (hd && wr_tx_ncnt); // see RULE15
   wire [31:0] tx_cur_a = hd ? rx_current_address : tx_current_address;
   wire [15:0] tx_cur_s = hd ? rx_current_size : tx_current_size;
   wire [31:0] tx_q_a = hd ? rx_queued_address : tx_queued_address;
   wire [15:0] tx_q_s = hd ? rx_queued_size : tx_queued_size;

   // Control decode; the bit positions are also the write strobes
   wire rx_en_w = wr_ctrl && sel_i[0] && dat_i[`BIT_RX_EN]; // see RULE20
   wire rx_dis_w = wr_ctrl && sel_i[0] && dat_i[`BIT_RX_DIS];
   wire tx_en_w = wr_ctrl && sel_i[1] && dat_i[`BIT_TX_EN];
   wire tx_dis_w = wr_ctrl && sel_i[1] && dat_i[`BIT_TX_DIS];
   wire any_dis = rx_dis_w || tx_dis_w;
   // Disable wins over enable; in half duplex rx enable wins over tx enable
   wire next_rx_en = (hd ? any_dis : rx_dis_w) ? 1'b0 : (rx_en_w ? 1'b1 : rx_request_enable); // see RULE16 see RULE18
   wire next_tx_en = (hd ? any_dis : tx_dis_w) ? 1'b0 :
      (hd && rx_en_w) ? 1'b0 : (tx_en_w ? 1'b1 : tx_request_enable); // see RULE17 see RULE18

   // Synchronised peripheral readiness
   logic rx_ready;
   logic tx_ready;
   pdc_sync u_rx_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i(rx_ready_i),
      .q_o(rx_ready)
   );
   pdc_sync u_tx_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i(tx_ready_i),
      .q_o(tx_ready)
   );

   logic rx_step;
   logic tx_step;
   pdc_dir #(.STEP(STEP)) u_rx_dir (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .enable_i(rx_request_enable),
      .count_i(rx_current_size),
      .periph_ready_i(rx_ready),
      .req_o(rx_req_o),
      .ack_i(rx_ack_i),
      .step_o(rx_step)
   );
   pdc_dir #(.STEP(STEP)) u_tx_dir (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .enable_i(tx_request_enable),
      .count_i(tx_cur_s),
      .periph_ready_i(tx_ready),
      .req_o(tx_req_o),
      .ack_i(tx_ack_i),
      .step_o(tx_step)
   );

   // Advance and reload; a software write in the same cycle takes precedence
   wire rx_adv = rx_step || (hd && tx_step);
   // A beat starts only on a live count, but a count written to zero mid-beat still decrements and wraps
   wire [15:0] rx_dec = rx_current_size - `CNT_ONE;
   wire [15:0] tx_dec = tx_current_size - `CNT_ONE;
   wire rx_reload = rx_adv && rx_dec == `RST_CNT;
   wire tx_reload = !hd && tx_step && tx_dec == `RST_CNT;
   wire [31:0] step32 = 32'(STEP);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_current_address <= `RST_PTR;
         rx_queued_address <= `RST_PTR;
      end else if (ce_i) begin
         if (sel_rx_ptr) begin
            rx_current_address <= merge32(rx_current_address, dat_i, sel_i);
         end else if (rx_reload) begin
            rx_current_address <= rx_queued_address; // see RULE21
         end else if (rx_adv) begin
            rx_current_address <= rx_current_address + step32; // see RULE21
         end
         if (sel_rx_nptr) begin
            rx_queued_address <= merge32(rx_queued_address, dat_i, sel_i); // see RULE8
         end
      end
   end

   // Counts: a software write in the same cycle as a step wins and the step is lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_current_size <= `RST_CNT;
         rx_queued_size <= `RST_CNT;
      end else if (ce_i) begin
         if (sel_rx_cnt) begin
            rx_current_size <= merge16(rx_current_size, dat_i, sel_i);
         end else if (rx_reload) begin
            rx_current_size <= rx_queued_size;
         end else if (rx_adv) begin
            rx_current_size <= rx_dec;
         end
         if (sel_rx_ncnt) begin
            rx_queued_size <= merge16(rx_queued_size, dat_i, sel_i); // see RULE9
         end else if (rx_reload) begin
            rx_queued_size <= `RST_CNT;
         end
      end
   end

   // Tx copies still take tx-offset writes in half duplex; only their stepping stops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_current_address <= `RST_PTR;
         tx_queued_address <= `RST_PTR;
      end else if (ce_i) begin
         if (wr_tx_ptr) begin
            tx_current_address <= merge32(tx_current_address, dat_i, sel_i);
         end else if (tx_reload) begin
            tx_current_address <= tx_queued_address; // see RULE21
         end else if (tx_step && !hd) begin
            tx_current_address <= tx_current_address + step32;
         end
         if (wr_tx_nptr) begin
            tx_queued_address <= merge32(tx_queued_address, dat_i, sel_i); // see RULE10
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_current_size <= `RST_CNT;
         tx_queued_size <= `RST_CNT;
      end else if (ce_i) begin
         if (wr_tx_cnt) begin
            tx_current_size <= merge16(tx_current_size, dat_i, sel_i);
         end else if (tx_reload) begin
            tx_current_size <= tx_queued_size;
         end else if (tx_step && !hd) begin
            tx_current_size <= tx_dec;
         end
         if (wr_tx_ncnt) begin
            tx_queued_size <= merge16(tx_queued_size, dat_i, sel_i); // see RULE11
         end else if (tx_reload) begin
            tx_queued_size <= `RST_CNT;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_request_enable <= 1'b0;
         tx_request_enable <= 1'b0;
         half_duplex <= 1'b0;
      end else if (ce_i) begin
         rx_request_enable <= next_rx_en;
         tx_request_enable <= next_tx_en;
         if (wr_cfg && sel_i[0]) begin
            half_duplex <= dat_i[`BIT_HALF_DUPLEX];
         end
      end
   end

   // Read mux; control register is write-only and reads as zero
   logic [31:0] rd_mux;
   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`BIT_RX_EN] = rx_request_enable; // see RULE19
      status_word[`BIT_TX_EN] = tx_request_enable;
      case (adr_i)
         `OFS_RX_PTR: rd_mux = rx_current_address;
         `OFS_RX_CNT: rd_mux = {16'h0000, rx_current_size};
         `OFS_TX_PTR: rd_mux = tx_cur_a;
         `OFS_TX_CNT: rd_mux = {16'h0000, tx_cur_s};
         `OFS_RX_NPTR: rd_mux = rx_queued_address;
         `OFS_RX_NCNT: rd_mux = {16'h0000, rx_queued_size};
         `OFS_TX_NPTR: rd_mux = tx_q_a;
         `OFS_TX_NCNT: rd_mux = {16'h0000, tx_q_s};
         `OFS_STATUS: rd_mux = status_word;
         `OFS_CONFIG: rd_mux = {31'h0000_0000, half_duplex};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // One wait state: ack a cycle after strobe, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_o <= access;
         if (access && !we_i) begin
            dat_o <= rd_mux;
         end
      end
   end

   assign rx_addr_o = rx_current_address;
   assign tx_addr_o = tx_cur_a;
endmodule : pdc_channel
`default_nettype wire

// ==== sim/pdc_channel_props.sv ====
// Port-level checks of the DMA channel pair
`timescale 1ns/1ps
`default_nettype none
module pdc_channel_props #(
   parameter int unsigned STEP = 4
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Peripheral and memory side
   input wire logic rx_ready_i,
   input wire logic tx_ready_i,
   input wire logic rx_req_o,
   input wire logic [31:0] rx_addr_o,
   input wire logic rx_ack_i,
   input wire logic tx_req_o,
   input wire logic [31:0] tx_addr_o,
   input wire logic tx_ack_i
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire take = cyc_i && stb_i && ce_i && !ack_o;
   sequence s_rx_beat;
      rx_req_o && rx_ack_i;
   endsequence
   sequence s_tx_beat;
      tx_req_o && tx_ack_i;
   endsequence
   a_bus_answer: assert property (take |=> ack_o) else $error("no ack after request");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i)) else $error("ack without request");
   a_rd_hold: assert property (!ack_o |-> $stable(dat_o)) else $error("read data moved");
   a_rx_req_hold: assert property (rx_req_o && !rx_ack_i |=> rx_req_o) else $error("rx req dropped");
   a_tx_req_hold: assert property (tx_req_o && !tx_ack_i |=> tx_req_o) else $error("tx req dropped");
   a_rx_beat_gap: assert property (s_rx_beat |=> !rx_req_o [*2]) else $error("rx beats too close");
   a_tx_beat_gap: assert property (s_tx_beat |=> !tx_req_o ##1 !tx_req_o) else $error("tx beats too close");
   a_rx_addr_stand: assert property (rx_req_o && $past(rx_req_o) && !ack_o |-> $stable(rx_addr_o))
      else $error("rx address moved in beat");
   a_tx_addr_stand: assert property (tx_req_o && $past(tx_req_o) && !ack_o |-> $stable(tx_addr_o))
      else $error("tx address moved in beat");
endmodule : pdc_channel_props
bind pdc_channel pdc_channel_props #(.STEP(STEP)) pdc_channel_props_i (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i,
   .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rx_ready_i, .tx_ready_i, .rx_req_o, .rx_addr_o, .rx_ack_i,
   .tx_req_o, .tx_addr_o, .tx_ack_i);
`default_nettype wire

// ==== sim/pdc_partner.sv ====
// Peripheral and memory model for both directions: random ready, slow or prompt ack
`timescale 1ns/1ps
`default_nettype none
module pdc_partner (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Per direction, bit 0 receive, bit 1 transmit
   input wire logic [1:0] req_i,
   output logic [1:0] ready_o,
   output logic [1:0] ack_o
);
   int wait_n [2] = '{0, 0};
   initial begin
      ready_o = 2'b00;
      ack_o = 2'b00;
   end
   always @(posedge clk_i) begin
      for (int d = 0; d < 2; d++) begin
         // Bursty ready keeps the request latency varying
         ready_o[d] <= !rst_i && ($urandom % 4 != 0);
         ack_o[d] <= !rst_i && req_i[d] && !ack_o[d] && wait_n[d] == 0;
         if (rst_i || !req_i[d] || ack_o[d]) begin
            wait_n[d] <= $urandom % 4;
         end else if (wait_n[d] != 0) begin
            wait_n[d] <= wait_n[d] - 1;
         end
      end
   end
endmodule : pdc_partner
`default_nettype wire

// ==== sim/test_peripheral_dma_channel_regs.sv ====
// Self-checking bench of the DMA channel pair against a register model
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_dma_channel_regs;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] mdl [0:11] = '{default: 32'h0};
   wire [31:0] dat_o, rx_addr_o, tx_addr_o;
   wire ack_o, rx_req_o, tx_req_o, rx_ready_i, tx_ready_i, rx_ack_i, tx_ack_i;
   int n_errors = 0, n_tests = 0, cycles = 0, c = 0;
   int nb [2] = '{0, 0};
   always #2 clk_i = ~clk_i;
   pdc_channel #(.STEP(4)) pdc_channel_i (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .rx_ready_i, .tx_ready_i, .rx_req_o, .rx_addr_o, .rx_ack_i,
      .tx_req_o, .tx_addr_o, .tx_ack_i);
   pdc_partner pdc_partner_i (.clk_i, .rst_i, .req_i({tx_req_o, rx_req_o}), .ready_o({tx_ready_i, rx_ready_i}),
      .ack_o({tx_ack_i, rx_ack_i}));
   task automatic wrap_up;
      $display("Errors %0d, checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Model slot of an offset; half duplex folds the transmit copies onto receive
   function automatic int idx(input logic [7:0] a);
      int i;
      i = a[5:2];
      if (mdl[10][0] && i inside {2, 3, 6, 7}) i -= 2;
      return (a > 8'h28) ? 11 : i;
   endfunction : idx
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      int i;
      i = idx(a);
      bus(a, 1'b1, d, q);
      if (i < 8) mdl[i] = i[0] ? {16'h0000, d[15:0]} : d;
      // Half duplex tx-offset writes also land in the hidden tx copies
      if (i < 8 && mdl[10][0] && a[3]) mdl[i + 2] = mdl[i];
      if (i == 10) mdl[10] = {31'h0, d[0]};
      if (i == 8 && mdl[10][0] && (d[1] || d[9])) mdl[9] = 32'h0;
      else if (i == 8 && mdl[10][0] && d[0]) mdl[9] = 32'h1;
      else if (i == 8) begin
         if (d[1]) mdl[9][0] = 1'b0;
         else if (d[0]) mdl[9][0] = 1'b1;
         if (d[9]) mdl[9][8] = 1'b0;
         else if (d[8]) mdl[9][8] = 1'b1;
      end
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(q, mdl[idx(a)]);
   endtask : rd
   task automatic step(input int b, input logic [31:0] got);
      chk({31'h0, mdl[b + 1] == 0}, 32'h0);
      chk(got, mdl[b]);
      mdl[b] += 4;
      mdl[b + 1] -= 1;
      if (mdl[b + 1] == 0) begin
         mdl[b] = mdl[b + 4];
         mdl[b + 1] = mdl[b + 5];
         mdl[b + 5] = 32'h0;
      end
      nb[b / 2]++;
   endtask : step
   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         wrap_up();
      end
      if (rx_req_o && rx_ack_i) step(0, rx_addr_o);
      if (tx_req_o && tx_ack_i) step(2, tx_addr_o);
   end
   initial begin
      void'($urandom(32'h3CA2));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int a = 0; a <= 8'h28; a += 4) rd(8'(a));
      wr(8'hFC, $urandom);
      rd(8'hFC);
      // Zero counts: enabled channels must stay quiet
      for (int k = 0; k < 4; k++) begin
         wr(8'h20, k[0] ? 32'h003 : 32'h101);
         rd(8'h24);
         wr(8'h20, k[1] ? 32'h200 : 32'h000);
         rd(8'h24);
      end
      wr(8'h20, 32'h202);
      for (int a = 0; a < 8'h20; a += 4) wr(8'(a), $urandom);
      wr(8'h04, 32'hFFFF_FFFF);
      for (int a = 0; a < 8'h20; a += 4) rd(8'(a));
      wr(8'h28, 32'h1);
      for (int a = 0; a < 8'h18; a += 4) begin
         if (a[3] == 1'b0) wr(8'(a + 8), $urandom);
         if (a[3] == 1'b0) rd(8'(a));
      end
      wr(8'h0C, 32'h0);
      rd(8'h04);
      wr(8'h20, 32'h101);
      rd(8'h24);
      wr(8'h20, 32'h002);
      wr(8'h20, 32'h100);
      rd(8'h24);
      wr(8'h20, 32'h200);
      rd(8'h24);
      wr(8'h28, 32'h0);
      // Full duplex traffic, receive runs into its queued buffer
      wr(8'h00, $urandom);
      wr(8'h04, 1 + $urandom % 4);
      wr(8'h10, $urandom);
      wr(8'h14, 1 + $urandom % 3);
      wr(8'h0C, 32'h0);
      wr(8'h1C, 32'h0);
      c = mdl[1] + mdl[5];
      wr(8'h20, 32'h101);
      while (nb[0] < c) rd(8'h24);
      repeat (4) @(posedge clk_i);
      for (int a = 0; a < 8'h20; a += 4) rd(8'(a));
      chk(32'(nb[1]), 32'h0);
      wr(8'h08, $urandom);
      wr(8'h0C, 32'h2);
      while (nb[1] < 2) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      for (int a = 0; a < 8'h20; a += 4) rd(8'(a));
      chk(32'(nb[0]), 32'(c));
      wrap_up();
   end
endmodule : test_peripheral_dma_channel_regs
`default_nettype wire
